/* design/wwd_map.vh */
`ifndef WWD_MAP_VH
`define WWD_MAP_VH
// Notes on behaviour
// - At reset, only the flag matching the reset source is updated, except power-on, which loads all flags.
// - Hardware returns reset-cause flags to inactive only at power-on; otherwise software does that.
// - Software may write flags active; such writes never start a reset.
// - Time-out without a clear instruction requests a device reset.
// - In windowed operation a clear is accepted only while the window is open.
// - Period code n up to 10010 divides watchdog clock by 2^(n+5).
// - Reserved period codes 10011 to 11111 use the minimum ratio 1:32.
// - Period config 11111: field resets to 01011, writable; else config value, read-only.
// - Software enable bit works only in mode 01; ignored in other modes.
// - Clock select 000 picks low-frequency clock, 001 medium; others reserved.
// - Clock config 111: select resets to 000, writable; else follows config, read-only.
// - Window code 111 is fully open; code k opens final (k+1) eighths.
// - Window field resets to window config; writable only when config is 111.
// - Eighteen-bit prescale counter is readable, read-only, resets to zero, split over three registers.
// - Window counter in timer bits 7:3; open when count reaches 4x(7-k).
// - Timer bit 2 reads 1 while armed, 0 otherwise.
// - Modes 1x enable clock by config; mode 01 uses software enable and select field.
// - Mode 11 always runs, also during Sleep.
// - Mode 10 runs while awake, no protection during Sleep.
// - Mode 01 follows software enable alone; Sleep does not change it.
// - A clear outside the open window is a violation and causes a watchdog reset.
// - Windowed clear needs a prior arm by reading control register 0.
// - A violation clears the violation flag active-low; power-on or software sets it.
// - Any write to either control register clears the watchdog counters.

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define WWD_ADDR_FLAGS   8'h00
`define WWD_ADDR_CTRL0   8'h04
`define WWD_ADDR_CTRL1   8'h08
`define WWD_ADDR_PSLOW   8'h0c
`define WWD_ADDR_PSHIGH  8'h10
`define WWD_ADDR_TIMER   8'h14
`define WWD_ADDR_CLEAR   8'h18

// ----------------------------------------
// Field positions and values
// ----------------------------------------
`define WWD_FLAG_STACK_OVERFLOW_FLAG  7
`define WWD_FLAG_STACK_UNDERFLOW_FLAG  6
`define WWD_FLAG_WINVIO  5
`define WWD_FLAG_WDRST   4
`define WWD_FLAG_PINRST  3
`define WWD_FLAG_INSTR   2
`define WWD_FLAG_POR     1
`define WWD_FLAG_BOR     0
`define WWD_PS_MAXCODE   5'h12
`define WWD_PS_UNLOCK    5'h1f
`define WWD_PS_DEFAULT   5'h0b
`define WWD_CS_UNLOCK    3'h7
`define WWD_CS_DEFAULT   3'h0
`define WWD_WIN_UNLOCK   3'h7
`define WWD_MODE_SW      2'h1
`define WWD_MODE_AWAKE   2'h2
`define WWD_MODE_ALWAYS  2'h3
`define WWD_FLAGS_POR    8'h3c
`endif

/* design/wwd_tick_sync.v */
`timescale 1ns/100ps
// Edge detector for a watchdog oscillator tick, taken as synchronous input.
module wwd_tick_sync (
  input  wire clk,
  input  wire resetn,
  input  wire level,
  output wire rise
);
  reg last_q;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      last_q <= 1'h0;
    end else begin
      last_q <= level;
    end
  end
  assign rise = level & ~last_q;
endmodule

/* design/wwd_top.v */
`timescale 1ns/100ps
`include "wwd_map.vh"
module wwd_top (
  input  wire        clk,
  input  wire        resetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [1:0]  watchdogModeConfig,
  input  wire [4:0]  periodConfigField,
  input  wire [2:0]  clockConfigField,
  input  wire [2:0]  windowConfigField,
  input  wire        lowFreqInternalOsc,
  input  wire        mediumFreqInternalOsc,
  input  wire        sleepMode,
  input  wire        watchdogClearInstruction,
  input  wire        causePowerOn,
  input  wire        causeBrownOut,
  input  wire        causeExternalPin,
  input  wire        causeResetInstruction,
  input  wire        causeStackOverflow,
  input  wire        causeStackUnderflow,
  output reg         watchdogResetReq
);
  // ----------------------------------------
  // Register state
  // ----------------------------------------
  reg  [7:0]  flags_q;
  reg  [7:0]  flags_d;
  reg  [4:0]  periodSel_q;
  reg  [4:0]  periodSel_d;
  reg         swEnable_q;
  reg         swEnable_d;
  reg  [2:0]  clockSel_q;
  reg  [2:0]  clockSel_d;
  reg  [2:0]  windowSel_q;
  reg  [2:0]  windowSel_d;
  reg  [17:0] prescale_q;
  reg  [17:0] prescale_d;
  reg  [4:0]  winCount_q;
  reg  [4:0]  winCount_d;
  reg         armed_q;
  reg         armed_d;
  reg         loaded_q;
  reg         prevCause_q;
  reg  [31:0] rdata_d;
  reg         slverr_d;
  wire        lfTick;
  wire        mfTick;
  wire        winOpen;
  wire        periodUnlocked;
  wire        clockUnlocked;
  wire        windowUnlocked;
  wire [4:0]  effPeriod;
  wire [2:0]  effClock;
  wire [2:0]  effWindow;
  wire        reservedPeriod;
  wire        running;
  wire        tick;
  wire [17:0] stepMask;
  wire        step;
  wire        timeout;
  wire        windowed;
  wire        clearReq;
  wire        violation;
  wire        setupCycle;
  wire        wrAccess;
  wire        rdAccess;
  wire        selFlags;
  wire        selCtrl0;
  wire        selCtrl1;
  wire        wrFlags;
  wire        wrCtrl0;
  wire        wrCtrl1;
  wire        rdCtrl0;
  wire        ctrlWrite;
  wire        anyCause;
  wire        causeEdge;
  wire        counterClear;

  wwd_tick_sync uLf (
    .clk    (clk),
    .resetn (resetn),
    .level  (lowFreqInternalOsc),
    .rise   (lfTick)
  );
  wwd_tick_sync uMf (
    .clk    (clk),
    .resetn (resetn),
    .level  (mediumFreqInternalOsc),
    .rise   (mfTick)
  );
  wwd_window_check uWin (
    .count  (winCount_q),
    .winSel (effWindow),
    .isOpen (winOpen)
  );

  // ----------------------------------------
  // Access decode
  // ----------------------------------------
  assign setupCycle = psel & ~penable;
  assign wrAccess   = psel & penable & pready & pwrite;
  assign rdAccess   = psel & penable & pready & ~pwrite;
  assign selFlags   = paddr == `WWD_ADDR_FLAGS;
  assign selCtrl0   = paddr == `WWD_ADDR_CTRL0;
  assign selCtrl1   = paddr == `WWD_ADDR_CTRL1;
  assign wrFlags    = wrAccess & selFlags;
  assign wrCtrl0    = wrAccess & selCtrl0;
  assign wrCtrl1    = wrAccess & selCtrl1;
  assign rdCtrl0    = rdAccess & selCtrl0;
  assign ctrlWrite  = wrCtrl0 | wrCtrl1;
  assign anyCause   = causePowerOn | causeBrownOut | causeExternalPin | causeResetInstruction
                    | causeStackOverflow | causeStackUnderflow;
  assign causeEdge  = anyCause & ~prevCause_q;

  // Locked fields track the configuration directly, so a changed strap shows at once.
  assign periodUnlocked = periodConfigField == `WWD_PS_UNLOCK;
  assign clockUnlocked  = clockConfigField == `WWD_CS_UNLOCK;
  assign windowUnlocked = windowConfigField == `WWD_WIN_UNLOCK;
  assign effPeriod      = periodUnlocked ? periodSel_q : periodConfigField;
  assign effClock       = clockUnlocked ? clockSel_q : clockConfigField;
  assign effWindow      = windowUnlocked ? windowSel_q : windowConfigField;

  // ----------------------------------------
  // Run control and time base
  // ----------------------------------------
  assign running = (watchdogModeConfig == `WWD_MODE_ALWAYS)
                 | ((watchdogModeConfig == `WWD_MODE_AWAKE) & ~sleepMode)
                 | ((watchdogModeConfig == `WWD_MODE_SW) & swEnable_q);
  // Reserved clock codes select no clock, so the counters stall there.
  assign tick = (effClock == 3'h0) ? lfTick : ((effClock == 3'h1) ? mfTick : 1'h0);
  assign reservedPeriod = effPeriod > `WWD_PS_MAXCODE;
  // Ratio 2^(n+5) over 32 window steps gives one step every 2^n prescaler ticks.
  assign stepMask     = reservedPeriod ? 18'h00000 : ((18'h00001 << effPeriod) - 18'h00001);
  assign step         = running & tick & ((prescale_q & stepMask) == stepMask);
  assign timeout      = step & (winCount_q == 5'h1f);
  assign windowed     = effWindow != 3'h7;
  assign clearReq     = running & watchdogClearInstruction;
  assign violation    = clearReq & windowed & (~winOpen | ~armed_q);
  assign counterClear = ~running | ctrlWrite | clearReq | anyCause;

  always @* begin
    prescale_d = prescale_q;
    winCount_d = winCount_q;
    armed_d    = armed_q;
    if (counterClear) begin
      prescale_d = 18'h00000;
      winCount_d = 5'h00;
      armed_d    = rdCtrl0 & ~clearReq;
    end else begin
      if (tick) begin
        if (step && reservedPeriod) begin
          prescale_d = 18'h00000;
        end else begin
          prescale_d = prescale_q + 18'h00001;
        end
      end
      if (step) begin
        winCount_d = winCount_q + 5'h01;
      end
      if (rdCtrl0) begin
        armed_d = 1'h1;
      end
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prescale_q <= 18'h00000;
    end else begin
      prescale_q <= prescale_d;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      winCount_q <= 5'h00;
    end else begin
      winCount_q <= winCount_d;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      armed_q <= 1'h0;
    end else begin
      armed_q <= armed_d;
    end
  end

  // ----------------------------------------
  // Reset-cause flags and control fields
  // ----------------------------------------
  always @* begin
    flags_d = flags_q;
    if (wrFlags) begin
      flags_d = pwdata[7:0];
    end
    // Hardware events come after the bus write so that they win in a shared cycle.
    if (timeout) begin
      flags_d[`WWD_FLAG_WDRST] = 1'h0;
    end
    if (violation) begin
      flags_d[`WWD_FLAG_WINVIO] = 1'h0;
    end
    if (causeEdge) begin
      if (causePowerOn) begin
        flags_d = `WWD_FLAGS_POR & 8'hfc;
      end else if (causeBrownOut) begin
        flags_d[`WWD_FLAG_BOR] = 1'h0;
      end else if (causeExternalPin) begin
        flags_d[`WWD_FLAG_PINRST] = 1'h0;
      end else if (causeResetInstruction) begin
        flags_d[`WWD_FLAG_INSTR] = 1'h0;
      end else if (causeStackOverflow) begin
        flags_d[`WWD_FLAG_STACK_OVERFLOW_FLAG] = 1'h1;
      end else begin
        flags_d[`WWD_FLAG_STACK_UNDERFLOW_FLAG] = 1'h1;
      end
    end
  end

  always @* begin
    periodSel_d = periodSel_q;
    swEnable_d  = swEnable_q;
    clockSel_d  = clockSel_q;
    windowSel_d = windowSel_q;
    if (!loaded_q) begin
      windowSel_d = windowConfigField;
    end
    if (wrCtrl0) begin
      if (periodUnlocked) begin
        periodSel_d = pwdata[5:1];
      end
      swEnable_d = pwdata[0];
    end
    if (wrCtrl1) begin
      if (clockUnlocked) begin
        clockSel_d = pwdata[6:4];
      end
      if (windowUnlocked) begin
        windowSel_d = pwdata[2:0];
      end
    end
    if (causeEdge) begin
      periodSel_d = `WWD_PS_DEFAULT;
      swEnable_d  = 1'h0;
      clockSel_d  = `WWD_CS_DEFAULT;
      windowSel_d = windowConfigField;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flags_q <= `WWD_FLAGS_POR;
    end else begin
      flags_q <= flags_d;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      periodSel_q <= `WWD_PS_DEFAULT;
    end else begin
      periodSel_q <= periodSel_d;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      swEnable_q <= 1'h0;
    end else begin
      swEnable_q <= swEnable_d;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      clockSel_q <= `WWD_CS_DEFAULT;
    end else begin
      clockSel_q <= clockSel_d;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      windowSel_q <= 3'h7;
    end else begin
      windowSel_q <= windowSel_d;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      loaded_q <= 1'h0;
    end else begin
      loaded_q <= 1'h1;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prevCause_q <= 1'h0;
    end else begin
      prevCause_q <= anyCause;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      watchdogResetReq <= 1'h0;
    end else begin
      watchdogResetReq <= timeout | violation;
    end
  end

  // ----------------------------------------
  // APB slave: no wait states, error on unmapped address
  // ----------------------------------------
  always @* begin
    slverr_d = 1'h0;
    rdata_d  = 32'h00000000;
    if (setupCycle) begin
      case (paddr)
        `WWD_ADDR_FLAGS:  rdata_d = {24'h000000, flags_q};
        `WWD_ADDR_CTRL0:  rdata_d = {24'h000000, 2'h0, effPeriod, swEnable_q};
        `WWD_ADDR_CTRL1:  rdata_d = {24'h000000, 1'h0, effClock, 1'h0, effWindow};
        `WWD_ADDR_PSLOW:  rdata_d = {24'h000000, prescale_q[7:0]};
        `WWD_ADDR_PSHIGH: rdata_d = {24'h000000, prescale_q[15:8]};
        `WWD_ADDR_TIMER:  rdata_d = {24'h000000, winCount_q, armed_q, prescale_q[17:16]};
        default:          slverr_d = 1'h1;
      endcase
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pready  <= 1'h0;
      pslverr <= 1'h0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= setupCycle;
      pslverr <= slverr_d;
      prdata  <= rdata_d;
    end
  end
endmodule

/* design/wwd_window_check.v */
`timescale 1ns/100ps
// Window-open decode from the five-bit window counter.
module wwd_window_check (
  input  wire [4:0] count,
  input  wire [2:0] winSel,
  output wire       isOpen
);
  wire [4:0] threshold;
  assign threshold = {(3'h7 - winSel), 2'h0};
  assign isOpen    = (winSel == 3'h7) | (count >= threshold);
endmodule

/* tb/windowed_watchdog_with_reset_flags_tb.sv */
`timescale 1ns/100ps
module windowed_watchdog_with_reset_flags_tb;
  logic        clk, resetn, psel, penable, pwrite, slow, fast, sleepMode, clr, slverr, pready, pslverr, req;
  logic [7:0]  paddr, rd;
  logic [31:0] pwdata, prdata;
  logic [1:0]  mode;
  logic [4:0]  perCfg;
  logic [2:0]  clkCfg, winCfg;
  logic [5:0]  cause;
  int          n_mismatch, n_checks, nReq, got;
  logic [7:0]  rstv [7] = '{8'h3c, 8'h16, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0]  cexp [6] = '{8'h3c, 8'h3e, 8'h37, 8'h3b, 8'hbf, 8'h7f};
  logic [20:0] row [6] = '{{1'h1, 2'h1, 2'h0, 16'h0701}, {1'h1, 2'h1, 2'h1, 16'h1727}, {1'h0, 2'h1, 2'h2, 16'h0700},
                           {1'h0, 2'h0, 2'h0, 16'h0701}, {1'h0, 2'h2, 2'h2, 16'h0701}, {1'h1, 2'h3, 2'h2, 16'h0701}};
  wwd_top DUT (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .watchdogModeConfig(mode),
    .periodConfigField(perCfg), .clockConfigField(clkCfg), .windowConfigField(winCfg),
    .lowFreqInternalOsc(slow), .mediumFreqInternalOsc(fast), .sleepMode(sleepMode),
    .watchdogClearInstruction(clr), .causePowerOn(cause[0]), .causeBrownOut(cause[1]),
    .causeExternalPin(cause[2]), .causeResetInstruction(cause[3]), .causeStackOverflow(cause[4]),
    .causeStackUnderflow(cause[5]), .watchdogResetReq(req));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // The request is held until pready is seen high; a missing answer ends the run.
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int i;
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      n_mismatch++;
      print_verdict;
    end
    rd = prdata[7:0];
    slverr = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic tick(input logic m);
    @(posedge clk);
    slow <= !m;
    fast <= m;
    repeat (3) @(posedge clk);
    slow <= 0;
    fast <= 0;
    repeat (3) @(posedge clk);
  endtask
  // Counts ticks until the first reset request; got stays 0 if none came.
  task automatic run(input logic m, input int n);
    int k;
    k = nReq;
    got = 0;
    for (int i = 1; i <= n; i++) begin
      tick(m);
      if (got == 0 && nReq != k) got = i;
    end
  endtask
  task automatic kick;
    @(posedge clk);
    clr <= 1;
    @(posedge clk);
    clr <= 0;
    repeat (4) @(posedge clk);
  endtask
  always @(posedge clk) if (req === 1'b1) nReq <= nReq + 1;
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    {resetn, psel, penable, pwrite, slow, fast, sleepMode, clr} = 8'h00;
    {paddr, pwdata, cause, nReq} = 0;
    {mode, perCfg, clkCfg, winCfg} = {2'h1, 5'h1f, 3'h7, 3'h7};
    repeat (16) @(posedge clk);
    resetn <= 1;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 7; i++) begin
      bus(0, 8'(i * 4), 8'h00);
      chk("reset value", rstv[i], rd);
      chk("error response", i == 6, slverr);
    end
    foreach (row[i]) begin
      mode <= row[i][19:18];
      sleepMode <= row[i][17];
      bus(1, 8'h08, row[i][15:8]);
      bus(1, 8'h04, row[i][7:0]);
      run(row[i][16], 40);
      chk("timeout seen", row[i][20], got != 0);
      if (got != 0) chk("ticks to timeout", 8'h20, 8'(got));
    end
    sleepMode <= 0;
    mode <= 2'h1;
    bus(0, 8'h00, 8'h00);
    chk("watchdog flag", 0, rd[4]);
    bus(1, 8'h00, 8'h3f);
    bus(1, 8'h08, 8'h00);
    bus(1, 8'h04, 8'h17);
    got = nReq;
    kick;
    chk("unarmed clear resets", 1, nReq != got);
    bus(0, 8'h00, 8'h00);
    chk("violation flags", 8'h1f, rd);
    bus(1, 8'h08, 8'h06);
    bus(1, 8'h04, 8'h01);
    bus(0, 8'h04, 8'h00);
    run(0, 6);
    bus(0, 8'h0c, 8'h00);
    chk("prescale low", 8'h06, rd);
    bus(0, 8'h14, 8'h00);
    chk("timer", 8'h34, rd);
    kick;
    run(0, 30);
    chk("clear in window", 0, got);
    for (int i = 0; i < 6; i++) begin
      bus(1, 8'h00, 8'h3f);
      cause <= 6'(1 << i);
      repeat (3) @(posedge clk);
      cause <= 6'h00;
      repeat (2) @(posedge clk);
      bus(0, 8'h00, 8'h00);
      chk("cause flags", cexp[i], rd);
    end
    bus(1, 8'h00, 8'hc0);
    bus(0, 8'h00, 8'h00);
    chk("flags set by write", 8'hc0, rd);
    {perCfg, clkCfg, winCfg} <= {5'h05, 3'h1, 3'h2};
    bus(1, 8'h04, 8'h3f);
    bus(0, 8'h04, 8'h00);
    chk("locked period", 8'h0b, rd);
    bus(1, 8'h08, 8'h77);
    bus(0, 8'h08, 8'h00);
    chk("locked clock window", 8'h12, rd);
    print_verdict;
  end
endmodule

/* tb/wwd_sva.sv */
`timescale 1ns/100ps
module wwd_sva (
  input wire        clk,
  input wire        resetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire [1:0]  watchdogModeConfig,
  input wire [4:0]  periodConfigField,
  input wire [2:0]  clockConfigField,
  input wire [2:0]  windowConfigField,
  input wire        watchdogResetReq
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  wire rdCyc = pready && !pwrite;
  req_pulse_a: assert property (watchdogResetReq |=> !watchdogResetReq)
    else $error("reset request wider than one cycle");
  off_mode_a: assert property ((watchdogModeConfig == 2'h0)[*3] |-> !watchdogResetReq)
    else $error("reset request while watchdog off");
  setup_ready_a: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  ctrl0_pad_a: assert property (rdCyc && paddr == 8'h04 |-> prdata[31:6] == 26'h0)
    else $error("unused control bits read nonzero");
  ctrl1_pad_a: assert property (rdCyc && paddr == 8'h08 |-> prdata[31:7] == 25'h0 && !prdata[3])
    else $error("unused control bits read nonzero");
  period_lock_a: assert property (rdCyc && paddr == 8'h04 && periodConfigField != 5'h1f
    |-> prdata[5:1] == periodConfigField) else $error("locked period differs");
  clock_lock_a: assert property (rdCyc && paddr == 8'h08 && clockConfigField != 3'h7
    |-> prdata[6:4] == clockConfigField) else $error("locked clock differs");
  window_lock_a: assert property (rdCyc && paddr == 8'h08 && windowConfigField != 3'h7
    |-> prdata[2:0] == windowConfigField) else $error("locked window differs");
endmodule
bind wwd_top wwd_sva uSva (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .watchdogModeConfig(watchdogModeConfig),
  .periodConfigField(periodConfigField), .clockConfigField(clockConfigField),
  .windowConfigField(windowConfigField), .watchdogResetReq(watchdogResetReq));
